// File: core/pm_i2c_regs.vh
`ifndef PM_I2C_REGS_VH
`define PM_I2C_REGS_VH

// Core clock rate used to turn times into cycle counts
`define PM_CLK_MHZ 100
// Spike suppression time on the lines, standard and high-speed
`define PM_T_SPIKE_STD_NS 40
`define PM_T_SPIKE_HS_NS 10
// Least times round up to whole cycles
`define PM_FILT_STD_CYC ((`PM_T_SPIKE_STD_NS * `PM_CLK_MHZ + 999) / 1000)
`define PM_FILT_HS_CYC ((`PM_T_SPIKE_HS_NS * `PM_CLK_MHZ + 999) / 1000)
// Cycles after reset during which a START is disregarded
`define PM_PWRUP_CYCLES 16'h0010
// Fixed upper bits of the slave address
`define PM_ADDR_PREFIX 3'h4
// Broadcast slave address 0111 111
`define PM_BCAST_ADDR 7'h3f
// Upper five bits of the high-speed master code 0000 1xxx
`define PM_MCODE_PREFIX 5'h01
// Word pointer after reset
`define PM_PTR_RESET 8'h00
// Highest word location that holds useful data
`define PM_PTR_MAX_VALID 8'h09
// Strap codes of an address-select pin
`define PM_STRAP_GND 2'h0
`define PM_STRAP_VCC 2'h1
`define PM_STRAP_SDA 2'h2
`define PM_STRAP_SCL 2'h3

`endif

// File: core/line_sync.v
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser followed by a stability filter whose length
// depends on the bus speed mode.
module line_sync #(
  parameter [3:0] STD_LEN = 4'h4,
  parameter [3:0] HS_LEN = 4'h1
) (
  input wire core_clk,
  input wire reset,
  input wire pin_in,
  input wire hs,
  output wire sync_out,
  output wire filt_out
);

  reg meta_ff;
  reg sync_ff;
  reg filt_ff;
  reg [3:0] cnt_ff;
  wire [3:0] len;

  assign len = hs ? HS_LEN : STD_LEN;
  assign sync_out = sync_ff;
  assign filt_out = filt_ff;

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      filt_ff <= 1'b1;
      cnt_ff <= 4'h0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      // Output follows only after the new level has held len cycles
      if (sync_ff == filt_ff)
        cnt_ff <= 4'h0;
      else if (cnt_ff + 4'h1 >= len)
      begin
        filt_ff <= sync_ff;
        cnt_ff <= 4'h0;
      end
      else
        cnt_ff <= cnt_ff + 4'h1;
    end
  end

endmodule // line_sync

`default_nettype wire

// File: core/strap_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "pm_i2c_regs.vh"

// Works out what each address-select pin is tied to by watching it
// against the bus lines. Evidence only accumulates, so the address
// settles once the bus has toggled.
module strap_decode (
  input wire core_clk,
  input wire reset,
  input wire addr_select_pin_low,
  input wire addr_select_pin_high,
  input wire sda_sync,
  input wire scl_sync,
  output wire [6:0] slave_addr
);

  wire [1:0] pins;
  wire [3:0] codes;
  reg [6:0] addr_ff;
  reg [1:0] vld_ff;

  assign pins = {addr_select_pin_high, addr_select_pin_low};
  assign slave_addr = addr_ff;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_pin
      reg meta_ff;
      reg sync_ff;
      reg seen_hi_ff;
      reg seen_lo_ff;
      reg diff_sda_ff;
      reg diff_scl_ff;
      always @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          seen_hi_ff <= 1'b0;
          seen_lo_ff <= 1'b0;
          diff_sda_ff <= 1'b0;
          diff_scl_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= pins[i];
          sync_ff <= meta_ff;
          // Reset values still in the synchronisers are not evidence
          if (vld_ff[1])
          begin
            if (sync_ff)
              seen_hi_ff <= 1'b1;
            else
              seen_lo_ff <= 1'b1;
            if (sync_ff != sda_sync)
              diff_sda_ff <= 1'b1;
            if (sync_ff != scl_sync)
              diff_scl_ff <= 1'b1;
          end
        end
      end
      assign codes[2*i+1:2*i] = !seen_hi_ff ? `PM_STRAP_GND :
                                !seen_lo_ff ? `PM_STRAP_VCC :
                                !diff_sda_ff ? `PM_STRAP_SDA :
                                `PM_STRAP_SCL;
    end
  endgenerate

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      vld_ff <= 2'h0;
      addr_ff <= {`PM_ADDR_PREFIX, `PM_STRAP_GND, `PM_STRAP_GND};
    end
    else
    begin
      vld_ff <= {vld_ff[0], 1'b1};
      addr_ff <= {`PM_ADDR_PREFIX, codes[3:2], codes[1:0]};
    end
  end

endmodule // strap_decode

`default_nettype wire

// File: core/power_monitor_i2c_slave.v
`timescale 1ns/1ns
`default_nettype none
`include "pm_i2c_regs.vh"

module power_monitor_i2c_slave #(
  parameter [15:0] PWRUP_CYCLES = `PM_PWRUP_CYCLES
) (
  input wire core_clk,
  input wire reset,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire addr_select_pin_low,
  input wire addr_select_pin_high,
  output wire [7:0] reg_ptr,
  input wire [15:0] rd_data,
  output wire [15:0] wr_data,
  output wire wr_strobe,
  output wire hs_mode,
  output wire busy
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_WORD = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_IGNORE = 3'h5;

  localparam integer FILT_STD_N = `PM_FILT_STD_CYC;
  localparam integer FILT_HS_N = `PM_FILT_HS_CYC;
  localparam [3:0] FILT_STD = FILT_STD_N[3:0];
  localparam [3:0] FILT_HS = FILT_HS_N[3:0];

  reg [2:0] state_ff;
  reg [3:0] bitcnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] tx_ff;
  reg [7:0] word_lo_ff;
  reg ack_phase_ff;
  reg byte_lo_ff;
  reg rw_ff;
  reg master_ack_ff;
  reg sda_oe_ff;
  reg [7:0] ptr_ff;
  reg [15:0] wr_data_ff;
  reg wr_strobe_ff;
  reg hs_ff;
  reg busy_ff;
  reg [15:0] pwr_cnt_ff;
  reg ready_ff;
  reg scl_prev_ff;
  reg sda_prev_ff;

  wire scl_f;
  wire sda_f;
  wire scl_s;
  wire sda_s;
  wire [6:0] own_addr;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire is_mcode;
  wire own_hit;
  wire bcast_hit;

  // Open-drain data pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign reg_ptr = ptr_ff;
  assign wr_data = wr_data_ff;
  assign wr_strobe = wr_strobe_ff;
  assign hs_mode = hs_ff;
  assign busy = busy_ff;

  // Clock comes from the master and is only sampled here
  line_sync #(
    .STD_LEN(FILT_STD),
    .HS_LEN(FILT_HS)
  ) u_scl_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(scl_in),
    .hs(hs_ff),
    .sync_out(scl_s),
    .filt_out(scl_f)
  );

  line_sync #(
    .STD_LEN(FILT_STD),
    .HS_LEN(FILT_HS)
  ) u_sda_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(sda_in),
    .hs(hs_ff),
    .sync_out(sda_s),
    .filt_out(sda_f)
  );

  strap_decode u_strap (
    .core_clk(core_clk),
    .reset(reset),
    .addr_select_pin_low(addr_select_pin_low),
    .addr_select_pin_high(addr_select_pin_high),
    .sda_sync(sda_s),
    .scl_sync(scl_s),
    .slave_addr(own_addr)
  );

  assign scl_rise = scl_f & ~scl_prev_ff;
  assign scl_fall = ~scl_f & scl_prev_ff;
  // Data moving with the clock high is a bus condition, not data
  assign start_det = scl_f & scl_prev_ff & sda_prev_ff & ~sda_f;
  assign stop_det = scl_f & scl_prev_ff & ~sda_prev_ff & sda_f;
  assign is_mcode = shift_ff[7:3] == `PM_MCODE_PREFIX;
  assign own_hit = shift_ff[7:1] == own_addr;
  assign bcast_hit = (shift_ff[7:1] == `PM_BCAST_ADDR) & ~shift_ff[0];

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pwr_cnt_ff <= 16'h0000;
      ready_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_prev_ff <= scl_f;
      sda_prev_ff <= sda_f;
      if (!ready_ff)
      begin
        if (pwr_cnt_ff + 16'h0001 >= PWRUP_CYCLES)
          ready_ff <= 1'b1;
        pwr_cnt_ff <= pwr_cnt_ff + 16'h0001;
      end
    end
  end

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      word_lo_ff <= 8'h00;
      ack_phase_ff <= 1'b0;
      byte_lo_ff <= 1'b0;
      rw_ff <= 1'b0;
      master_ack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ptr_ff <= `PM_PTR_RESET;
      wr_data_ff <= 16'h0000;
      wr_strobe_ff <= 1'b0;
      hs_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      wr_strobe_ff <= 1'b0;
      busy_ff <= (state_ff != ST_IDLE);
      if (stop_det)
      begin
        // Standby; a STOP also ends high speed
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
        ack_phase_ff <= 1'b0;
        bitcnt_ff <= 4'h0;
        hs_ff <= 1'b0;
      end
      else if (start_det && ready_ff)
      begin
        // Repeated START keeps hs_ff as it is
        state_ff <= ST_ADDR;
        sda_oe_ff <= 1'b0;
        ack_phase_ff <= 1'b0;
        bitcnt_ff <= 4'h0;
      end
      else if (scl_rise)
      begin
        if (ack_phase_ff)
        begin
          if (state_ff == ST_RDATA)
            master_ack_ff <= ~sda_f;
        end
        else if (state_ff == ST_ADDR || state_ff == ST_WORD ||
                 state_ff == ST_WDATA)
        begin
          shift_ff <= {shift_ff[6:0], sda_f};
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end
        else if (state_ff == ST_RDATA)
          bitcnt_ff <= bitcnt_ff + 4'h1;
      end
      else if (scl_fall)
      begin
        if (ack_phase_ff)
        begin
          // End of the acknowledge clock
          ack_phase_ff <= 1'b0;
          bitcnt_ff <= 4'h0;
          sda_oe_ff <= 1'b0;
          case (state_ff)
            ST_ADDR:
            begin
              if (rw_ff)
              begin
                // Current-address or random read from the pointer
                state_ff <= ST_RDATA;
                tx_ff <= rd_data[15:8];
                word_lo_ff <= rd_data[7:0];
                byte_lo_ff <= 1'b0;
                sda_oe_ff <= ~rd_data[15];
              end
              else
                state_ff <= ST_WORD;
            end
            ST_WORD:
            begin
              state_ff <= ST_WDATA;
              byte_lo_ff <= 1'b0;
            end
            ST_WDATA:
            begin
              if (!byte_lo_ff)
                byte_lo_ff <= 1'b1;
              else
                state_ff <= ST_IGNORE;
            end
            ST_RDATA:
            begin
              if (!master_ack_ff)
                state_ff <= ST_IGNORE;
              else if (!byte_lo_ff)
              begin
                tx_ff <= word_lo_ff;
                byte_lo_ff <= 1'b1;
                sda_oe_ff <= ~word_lo_ff[7];
              end
              else
              begin
                // Master kept acknowledging: stream the next word
                tx_ff <= rd_data[15:8];
                word_lo_ff <= rd_data[7:0];
                byte_lo_ff <= 1'b0;
                sda_oe_ff <= ~rd_data[15];
              end
            end
            default:
              state_ff <= ST_IGNORE;
          endcase
        end
        else if (bitcnt_ff == 4'h8)
        begin
          case (state_ff)
            ST_ADDR:
            begin
              if (is_mcode)
              begin
                // Master code is never acknowledged
                hs_ff <= 1'b1;
                state_ff <= ST_IGNORE;
              end
              else if (own_hit || bcast_hit)
              begin
                rw_ff <= shift_ff[0];
                ack_phase_ff <= 1'b1;
                sda_oe_ff <= 1'b1;
              end
              else
                state_ff <= ST_IGNORE;
            end
            ST_WORD:
            begin
              ptr_ff <= shift_ff;
              ack_phase_ff <= 1'b1;
              sda_oe_ff <= 1'b1;
            end
            ST_WDATA:
            begin
              if (!byte_lo_ff)
                wr_data_ff[15:8] <= shift_ff;
              else
              begin
                wr_data_ff[7:0] <= shift_ff;
                wr_strobe_ff <= 1'b1;
              end
              ack_phase_ff <= 1'b1;
              sda_oe_ff <= 1'b1;
            end
            ST_RDATA:
            begin
              // Release so the master can acknowledge
              ack_phase_ff <= 1'b1;
              sda_oe_ff <= 1'b0;
              master_ack_ff <= 1'b0;
              if (byte_lo_ff)
                ptr_ff <= ptr_ff + 8'h01;
            end
            default:
              state_ff <= ST_IGNORE;
          endcase
        end
        else if (state_ff == ST_RDATA)
        begin
          // Next bit goes out just after the falling edge
          tx_ff <= {tx_ff[6:0], 1'b0};
          sda_oe_ff <= ~tx_ff[6];
        end
      end
    end
  end

endmodule // power_monitor_i2c_slave

`default_nettype wire

// File: test/power_monitor_i2c_slave_chk.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic [7:0] reg_ptr,
  input wire logic wr_strobe,
  input wire logic hs_mode,
  input wire logic busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // Checked while reset is held, so it carries its own disable
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |-> !sda_oe && !wr_strobe && !hs_mode && !busy)
    else $error("outputs active during reset");
  a_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_oe_hold_high: assert property (
    $rose(scl_in) |=> $stable(sda_oe) [*8])
    else $error("data drive moved during clock high");
  a_oe_needs_busy: assert property (sda_oe |-> busy)
    else $error("data driven while idle");
  a_idle_free: assert property ($fell(busy) |-> !sda_oe)
    else $error("idle entered with data line held");
  a_ptr_clk_low: assert property ($changed(reg_ptr) |-> !scl_in)
    else $error("pointer moved while clock high");
  a_strobe_one: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  a_strobe_ctx: assert property (wr_strobe |-> busy && !scl_in)
    else $error("write strobe outside a byte boundary");
  a_hs_on_stop: assert property ($fell(hs_mode) |-> scl_in)
    else $error("high speed left without a stop");
endmodule // i2c_slave_chk

bind power_monitor_i2c_slave i2c_slave_chk chk (
  .core_clk(core_clk), .reset(reset), .scl_in(scl_in), .sda_oe(sda_oe),
  .reg_ptr(reg_ptr), .wr_strobe(wr_strobe), .hs_mode(hs_mode),
  .busy(busy)
);
`default_nettype wire

// File: test/i2c_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// Bus master; one step of its link clock is 125 ns, and the clock
// line rests high between frames.
module i2c_master_model (
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  localparam int Q = 125;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Master alone drives the clock and opens every frame
  task automatic start;
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask
  task automatic stop;
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // Data moves a full step after the clock falls
  task automatic bit_io(input logic b, output logic r);
    #Q sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda_wire;
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// File: test/power_monitor_i2c_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none
module power_monitor_i2c_slave_bench;
  localparam logic [7:0] ADW = 8'h82;
  localparam logic [7:0] ADR = 8'h83;
  logic core_clk, reset, scl, sda_low, sda_wire, sda_out, sda_oe;
  logic wr_strobe, hs_mode, busy;
  logic strap_sel, addr_lo, addr_hi;
  logic [7:0] reg_ptr, hi, lo;
  logic [15:0] rd_data, wr_data;
  int n_fail, samples_checked, n_strobe;
  // Pull-up on the data line; any party pulling low wins
  assign sda_wire = ~((sda_oe & ~sda_out) | sda_low);
  // Straps tied high/low, or to the data and clock lines
  assign addr_lo = strap_sel ? sda_wire : 1'b1;
  assign addr_hi = strap_sel ? scl : 1'b0;
  i2c_master_model m (.sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  power_monitor_i2c_slave dut (
    .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_low(addr_lo),
    .addr_select_pin_high(addr_hi), .reg_ptr(reg_ptr), .rd_data(rd_data),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .hs_mode(hs_mode),
    .busy(busy)
  );
  function automatic logic [15:0] word_at(input logic [7:0] p);
    word_at = {p ^ 8'h5a, p + 8'h31};
  endfunction
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    rd_data <= #1 word_at(reg_ptr);
  always @(posedge core_clk)
    if (wr_strobe === 1'b1)
      n_strobe++;
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wb(input logic [7:0] d, input logic exp);
    logic a;
    m.wr_byte(d, a);
    check({15'h0, a}, {15'h0, exp});
  endtask
  task end_xfer;
    m.stop();
    for (int i = 0; i < 300 && busy !== 1'b0; i++)
      @(posedge core_clk);
    if (busy !== 1'b0)
    begin
      n_fail++;
      $display("unexpected at %0t: interface stuck busy", $time);
      print_verdict;
    end
  endtask
  task t_reset_state;
    check({14'h0, sda_oe, busy}, 16'h0);
    check({8'h0, reg_ptr}, 16'h0);
  endtask
  // Foreign address also lets the strap decoder see bus activity
  task t_foreign;
    m.start();
    wb(8'ha0, 1'b0);
    wb(8'h00, 1'b0);
    end_xfer;
  endtask
  task t_cur_read;
    m.start();
    wb(ADR, 1'b1);
    m.rd_byte(1'b1, hi);
    m.rd_byte(1'b0, lo);
    end_xfer;
    check({hi, lo}, word_at(8'h00));
    check({8'h0, reg_ptr}, 16'h1);
  endtask
  task t_write;
    int s0;
    s0 = n_strobe;
    m.start();
    wb(ADW, 1'b1);
    wb(8'h05, 1'b1);
    wb(8'ha5, 1'b1);
    wb(8'h3c, 1'b1);
    wb(8'h77, 1'b0);
    end_xfer;
    check(16'(n_strobe - s0), 16'h1);
    check(wr_data, 16'ha53c);
    check({8'h0, reg_ptr}, 16'h5);
  endtask
  task t_rand_read;
    logic [7:0] h2;
    logic [15:0] w2;
    m.start();
    wb(ADW, 1'b1);
    wb(8'h09, 1'b1);
    m.start();
    wb(ADR, 1'b1);
    m.rd_byte(1'b1, hi);
    m.rd_byte(1'b1, lo);
    m.rd_byte(1'b0, h2);
    end_xfer;
    check({hi, lo}, word_at(8'h09));
    w2 = word_at(8'h0a);
    check({h2, reg_ptr}, {w2[15:8], 8'h0a});
  endtask
  task t_bcast;
    m.start();
    wb(8'h7e, 1'b1);
    wb(8'h02, 1'b1);
    wb(8'h12, 1'b1);
    wb(8'h34, 1'b1);
    end_xfer;
    check(wr_data, 16'h1234);
    check({8'h0, reg_ptr}, 16'h2);
  endtask
  task t_hs;
    m.start();
    wb(8'h0b, 1'b0);
    check({15'h0, hs_mode}, 16'h1);
    m.start();
    wb(ADW, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'hbe, 1'b1);
    wb(8'hef, 1'b1);
    m.start();
    wb(ADW, 1'b1);
    check({15'h0, hs_mode}, 16'h1);
    end_xfer;
    check({15'h0, hs_mode}, 16'h0);
    check(wr_data, 16'hbeef);
  endtask
  // Straps only settle after a reset, so this one resets mid-run
  task t_straps;
    strap_sel = 1'b1;
    @(posedge core_clk);
    #1 reset = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    t_reset_state;
    repeat (30) @(posedge core_clk);
    t_foreign;
    m.start();
    wb(ADW, 1'b0);
    m.start();
    wb(8'h9c, 1'b1);
    wb(8'h03, 1'b1);
    wb(8'h5e, 1'b1);
    wb(8'h11, 1'b1);
    end_xfer;
    check(wr_data, 16'h5e11);
    check({8'h0, reg_ptr}, 16'h3);
  endtask
  initial
  begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    $display("unexpected at %0t: run timed out", $time);
    print_verdict;
  end
  initial
  begin
    core_clk = 1'b0;
    strap_sel = 1'b0;
    // Reset rises after time zero so that every flop sees the edge
    reset = 1'b0;
    #1 reset = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    t_reset_state;
    repeat (30) @(posedge core_clk);
    t_foreign;
    t_cur_read;
    t_write;
    t_rand_read;
    t_bcast;
    t_hs;
    t_straps;
    print_verdict;
  end
endmodule // power_monitor_i2c_slave_bench
`default_nettype wire
